// File: dv/bus_host.sv
// processor model driving the timer bus
`timescale 1ns/100ps
module bus_host (
    // clock
    input wire logic sys_clk,
    // bus to timer
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic port_select_hi,
    output logic port_select_lo,
    output logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic data_oe
);
    initial
    begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        {port_select_hi, port_select_lo} = 2'h0;
        data_in = 8'h00;
    end

    task automatic write_port(input logic [1:0] port, input logic [7:0] value);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        {port_select_hi, port_select_lo} <= port;
        data_in <= value;
        repeat (4) @(posedge sys_clk);
        wr_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        cs_n <= 1'b1;
        data_in <= ~value;
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic read_port(input logic [1:0] port, output logic [7:0] value, output logic oe);
        @(posedge sys_clk);
        cs_n <= 1'b0;
        {port_select_hi, port_select_lo} <= port;
        repeat (4) @(posedge sys_clk);
        rd_n <= 1'b0;
        repeat (7) @(posedge sys_clk);
        value = data_out;
        oe = data_oe;
        rd_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        cs_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
    endtask
endmodule

// File: dv/tb_top.sv
// self-checking bench for the interval timer
`timescale 1ns/100ps
`define CHK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("wrong value %s expected %h seen %h", what, exp, got); \
        end \
    end
module tb_top;
    logic sys_clk, rst_n, cs_n, rd_n, wr_n, port_select_hi, port_select_lo, data_oe, oe;
    logic [7:0] data_in, data_out, rdata;
    logic [2:0] count_clk, count_gate, count_out;
    int n_fail = 0;
    int n_tests = 0;

    interval_timer dut (.sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
        .count_clk(count_clk), .count_gate(count_gate), .count_out(count_out));
    bus_host host (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
        .port_select_hi(port_select_hi), .port_select_lo(port_select_lo),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic pulse(input int ch);
        @(posedge sys_clk);
        count_clk[ch] <= 1'b1;
        repeat (3) @(posedge sys_clk);
        count_clk[ch] <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic rd_chk(input logic [1:0] port, input logic [7:0] exp, input string what);
        host.read_port(port, rdata, oe);
        `CHK(what, exp, rdata)
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
        begin
            $display("STATUS OK");
        end
        else
        begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        finish_test();
    end

    initial
    begin
        rst_n = 1'b0;
        count_clk = 3'h0;
        count_gate = 3'h7;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // counter zero: two-byte access, status and count latches
        host.write_port(2'h3, 8'h30);
        host.write_port(2'h3, 8'hE2);
        rd_chk(2'h0, 8'h70, "status after mode set");
        host.write_port(2'h0, 8'h34);
        host.write_port(2'h0, 8'h12);
        pulse(0);
        host.write_port(2'h3, 8'h00);
        pulse(0);
        host.write_port(2'h3, 8'h00);
        rd_chk(2'h0, 8'h34, "latched low");
        pulse(0);
        rd_chk(2'h0, 8'h12, "latched high");
        rd_chk(2'h0, 8'h32, "live low");
        rd_chk(2'h0, 8'h12, "live high");
        host.write_port(2'h3, 8'hE2);
        rd_chk(2'h0, 8'h30, "status after transfer");
        $display("test counter zero done");
        // counters one and two: single-byte modes
        host.write_port(2'h3, 8'h50);
        host.write_port(2'h1, 8'hAB);
        pulse(1);
        rd_chk(2'h1, 8'hAB, "low only count");
        host.write_port(2'h3, 8'hA0);
        host.write_port(2'h2, 8'hCD);
        pulse(2);
        pulse(2);
        host.write_port(2'h3, 8'hC8);
        rd_chk(2'h2, 8'h20, "status first");
        rd_chk(2'h2, 8'hCC, "high only count");
        host.read_port(2'h3, rdata, oe);
        `CHK("control port drive", 1'b0, oe)
        $display("test single byte done");
        // counter one one-shot on a gate trigger, counter two decimal step
        host.write_port(2'h3, 8'h52);
        `CHK("one-shot idle out", 1'b1, count_out[1])
        host.write_port(2'h1, 8'h02);
        count_gate[1] <= 1'b0;
        repeat (4) @(posedge sys_clk);
        count_gate[1] <= 1'b1;
        pulse(1);
        `CHK("one-shot started", 1'b0, count_out[1])
        pulse(1);
        pulse(1);
        `CHK("one-shot ended", 1'b1, count_out[1])
        host.write_port(2'h3, 8'h91);
        host.write_port(2'h2, 8'h10);
        pulse(2);
        pulse(2);
        rd_chk(2'h2, 8'h09, "decimal step");
        $display("test one-shot and decimal done");
        finish_test();
    end
endmodule

// File: verilog/count_unit.sv
// 16-bit down counter with binary or packed decimal decrement
`timescale 1ns/100ps
module count_unit #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // control
    input wire logic load,
    input wire logic [WIDTH-1:0] load_value,
    input wire logic dec,
    input wire logic bcd,
    // state
    output logic [WIDTH-1:0] value
);

    if (WIDTH != timer_pkg::COUNT_WIDTH)
    begin : g_width_check
        $error("count_unit supports only a 16-bit count");
    end

    function automatic logic [WIDTH-1:0] bcd_dec(input logic [WIDTH-1:0] v);
        logic [WIDTH-1:0] r;
        logic borrow;
        r = v;
        borrow = 1'b1;
        for (int k = 0; k < WIDTH / 4; k++)
        begin
            if (borrow)
            begin
                if (v[4*k +: 4] == 4'h0)
                begin
                    r[4*k +: 4] = timer_pkg::BCD_DIGIT_MAX;
                end
                else
                begin
                    r[4*k +: 4] = v[4*k +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction

    // zero decrements to the top value, so a loaded zero spans the full range
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            value <= '0;
        end
        else if (load)
        begin
            value <= load_value;
        end
        else if (dec)
        begin
            value <= bcd ? bcd_dec(value) : value - WIDTH'(1);
        end
    end

    // ****************************************
    // checks
    // ****************************************
    a_bin_decrement: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dec && !load && !bcd |=> value == $past(value) - WIDTH'(1))
        else $error("binary count did not step down by one");

    a_zero_wraps_max: assert property (@(posedge sys_clk) disable iff (!rst_n)
        dec && !load && value == '0
        |=> value == (bcd ? {4{timer_pkg::BCD_DIGIT_MAX}} : timer_pkg::BIN_MAX))
        else $error("zero count did not wrap to the top value");

    a_load_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
        load |=> value == $past(load_value))
        else $error("count transfer did not reach the down counter");

endmodule

// File: verilog/interval_timer.sv
// three-channel interval timer: bus decode, programming, latches, readback
// ****************************************
// ****************************************
`timescale 1ns/100ps
module interval_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // processor bus
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic port_select_hi,
    input wire logic port_select_lo,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // counter pins
    input wire logic [2:0] count_clk,
    input wire logic [2:0] count_gate,
    output logic [2:0] count_out
);

    localparam int N = timer_pkg::NUM_COUNTERS;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [timer_pkg::BUS_WIDTH-1:0] bus_s1, bus_s2, bus_s3;
    logic [7:0] data_s1, data_s2;
    logic [2:0] clk_s1, clk_s2, clk_s3;
    logic [2:0] gate_s1, gate_s2, gate_s3;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_s1 <= 5'h1F;
            bus_s2 <= 5'h1F;
            bus_s3 <= 5'h1F;
            data_s1 <= 8'h00;
            data_s2 <= 8'h00;
            clk_s1 <= 3'h0;
            clk_s2 <= 3'h0;
            clk_s3 <= 3'h0;
            gate_s1 <= 3'h0;
            gate_s2 <= 3'h0;
            gate_s3 <= 3'h0;
        end
        else
        begin
            bus_s1 <= {cs_n, rd_n, wr_n, port_select_hi, port_select_lo};
            bus_s2 <= bus_s1;
            bus_s3 <= bus_s2;
            data_s1 <= data_in;
            data_s2 <= data_s1;
            clk_s1 <= count_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            gate_s1 <= count_gate;
            gate_s2 <= gate_s1;
            gate_s3 <= gate_s2;
        end
    end

    // ****************************************
    // bus events
    // ****************************************
    logic chip_sel;
    logic [1:0] port;
    logic wr_evt, rd_end, rd_act, ctrl_wr, multi;
    logic [1:0] word_sel, word_acc;

    assign chip_sel = !bus_s2[timer_pkg::BUS_CS];
    assign port = bus_s2[1:0];
    // write data taken as the write strobe rises
    assign wr_evt = chip_sel && bus_s2[timer_pkg::BUS_WR] && !bus_s3[timer_pkg::BUS_WR];
    assign rd_end = chip_sel && bus_s2[timer_pkg::BUS_RD] && !bus_s3[timer_pkg::BUS_RD];
    assign rd_act = chip_sel && !bus_s2[timer_pkg::BUS_RD] && port != timer_pkg::PORT_CTRL;
    assign ctrl_wr = wr_evt && port == timer_pkg::PORT_CTRL;
    assign word_sel = data_s2[timer_pkg::SEL_MSB:timer_pkg::SEL_LSB];
    assign word_acc = data_s2[timer_pkg::ACC_MSB:timer_pkg::ACC_LSB];
    assign multi = ctrl_wr && word_sel == timer_pkg::SEL_MULTI;

    // ****************************************
    // per-counter state
    // ****************************************
    logic [5:0] status_mode [N];
    logic [15:0] count_reg [N];
    logic [15:0] latch_val [N];
    logic [7:0] status_val [N];
    logic [15:0] value [N];
    logic [N-1:0] null_count, load_pending, armed, running, write_hi_next;
    logic [N-1:0] read_hi_next, count_latched, status_latched, trigger;
    logic [N-1:0] mode_set, cnt_latch_cmd, sts_latch_cmd, cnt_wr, rd_done;
    logic [N-1:0] tick, trig_mode, transfer, dec, zero_hit;

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            mode_set[i] = ctrl_wr && word_sel == 2'(i)
                && word_acc != timer_pkg::ACC_LATCH;
            cnt_latch_cmd[i] = (ctrl_wr && word_sel == 2'(i)
                && word_acc == timer_pkg::ACC_LATCH)
                || (multi && data_s2[timer_pkg::MULTI_SEL_LSB + i]
                && !data_s2[timer_pkg::MULTI_NOCOUNT_BIT]);
            sts_latch_cmd[i] = multi && data_s2[timer_pkg::MULTI_SEL_LSB + i]
                && !data_s2[timer_pkg::MULTI_NOSTATUS_BIT];
            cnt_wr[i] = wr_evt && port == 2'(i);
            rd_done[i] = rd_end && port == 2'(i);
            tick[i] = clk_s2[i] && !clk_s3[i];
            trig_mode[i] = status_mode[i][3:1] == timer_pkg::MODE_ONE_SHOT
                || status_mode[i][3:1] == timer_pkg::MODE_HW_STROBE;
            // edge modes reload from the register on each trigger
            transfer[i] = tick[i] && (trig_mode[i] ? (trigger[i] && armed[i])
                : load_pending[i]);
            dec[i] = tick[i] && !transfer[i] && running[i]
                && (trig_mode[i] || gate_s2[i]);
            zero_hit[i] = dec[i] && value[i] == timer_pkg::COUNT_ONE;
        end
    end

    genvar g;
    for (g = 0; g < N; g++)
    begin : g_counter
        count_unit #(
            .WIDTH(timer_pkg::COUNT_WIDTH)
        ) u_count (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .load(transfer[g]),
            .load_value(count_reg[g]),
            .dec(dec[g]),
            .bcd(status_mode[g][timer_pkg::BCD_BIT]),
            .value(value[g])
        );
    end

    // ****************************************
    // mode register copy
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < N; i++)
            begin
                status_mode[i] <= 6'h00;
            end
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (mode_set[i])
                begin
                    status_mode[i] <= data_s2[5:0];
                end
            end
        end
    end

    // ****************************************
    // count register, write pointer, null flag
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < N; i++)
            begin
                count_reg[i] <= 16'h0000;
            end
            null_count <= '0;
            load_pending <= '0;
            armed <= '0;
            running <= '0;
            write_hi_next <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (mode_set[i])
                begin
                    null_count[i] <= 1'b1;
                    load_pending[i] <= 1'b0;
                    armed[i] <= 1'b0;
                    running[i] <= 1'b0;
                    write_hi_next[i] <= 1'b0;
                end
                else
                begin
                    if (transfer[i])
                    begin
                        load_pending[i] <= 1'b0;
                        running[i] <= 1'b1;
                        null_count[i] <= 1'b0;
                    end
                    // a write in the transfer cycle wins over the clear
                    if (cnt_wr[i])
                    begin
                        case (status_mode[i][5:4])
                            timer_pkg::ACC_LOW:
                            begin
                                count_reg[i] <= {timer_pkg::FILL_BYTE, data_s2};
                                load_pending[i] <= 1'b1;
                                armed[i] <= 1'b1;
                                null_count[i] <= 1'b1;
                            end
                            timer_pkg::ACC_HIGH:
                            begin
                                count_reg[i] <= {data_s2, timer_pkg::FILL_BYTE};
                                load_pending[i] <= 1'b1;
                                armed[i] <= 1'b1;
                                null_count[i] <= 1'b1;
                            end
                            timer_pkg::ACC_BOTH:
                            begin
                                if (!write_hi_next[i])
                                begin
                                    count_reg[i][7:0] <= data_s2;
                                    write_hi_next[i] <= 1'b1;
                                end
                                else
                                begin
                                    count_reg[i][15:8] <= data_s2;
                                    write_hi_next[i] <= 1'b0;
                                    load_pending[i] <= 1'b1;
                                    armed[i] <= 1'b1;
                                    null_count[i] <= 1'b1;
                                end
                            end
                            default:
                            begin
                                write_hi_next[i] <= write_hi_next[i];
                            end
                        endcase
                    end
                end
            end
        end
    end

    // ****************************************
    // output latches and read pointer
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < N; i++)
            begin
                latch_val[i] <= 16'h0000;
                status_val[i] <= 8'h00;
            end
            count_latched <= '0;
            status_latched <= '0;
            read_hi_next <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (mode_set[i])
                begin
                    count_latched[i] <= 1'b0;
                    status_latched[i] <= 1'b0;
                    read_hi_next[i] <= 1'b0;
                end
                else
                begin
                    if (rd_done[i])
                    begin
                        if (status_latched[i])
                        begin
                            status_latched[i] <= 1'b0;
                        end
                        else if (status_mode[i][5:4] == timer_pkg::ACC_BOTH
                            && !read_hi_next[i])
                        begin
                            read_hi_next[i] <= 1'b1;
                        end
                        else
                        begin
                            read_hi_next[i] <= 1'b0;
                            count_latched[i] <= 1'b0;
                        end
                    end
                    if (cnt_latch_cmd[i] && !count_latched[i])
                    begin
                        latch_val[i] <= value[i];
                        count_latched[i] <= 1'b1;
                    end
                    if (sts_latch_cmd[i] && !status_latched[i])
                    begin
                        status_val[i] <= {count_out[i], null_count[i], status_mode[i]};
                        status_latched[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // gate trigger and output level
    // ****************************************
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trigger <= '0;
            count_out <= '0;
        end
        else
        begin
            for (int i = 0; i < N; i++)
            begin
                if (mode_set[i])
                begin
                    trigger[i] <= 1'b0;
                    count_out[i] <= data_s2[3:1] != timer_pkg::MODE_END_COUNT;
                end
                else
                begin
                    if (gate_s2[i] && !gate_s3[i])
                    begin
                        trigger[i] <= 1'b1;
                    end
                    else if (tick[i])
                    begin
                        trigger[i] <= 1'b0;
                    end
                    if (cnt_wr[i] && status_mode[i][3:1] == timer_pkg::MODE_END_COUNT)
                    begin
                        count_out[i] <= 1'b0;
                    end
                    else if (transfer[i]
                        && status_mode[i][3:1] == timer_pkg::MODE_ONE_SHOT)
                    begin
                        count_out[i] <= 1'b0;
                    end
                    else if (zero_hit[i])
                    begin
                        count_out[i] <= 1'b1;
                    end
                end
            end
        end
    end

    // ****************************************
    // read data path
    // ****************************************
    logic [7:0] rd_byte;
    logic [15:0] rd_word;

    always_comb
    begin
        rd_byte = 8'h00;
        rd_word = 16'h0000;
        for (int i = 0; i < N; i++)
        begin
            if (port == 2'(i))
            begin
                rd_word = count_latched[i] ? latch_val[i] : value[i];
                case (status_mode[i][5:4])
                    timer_pkg::ACC_HIGH: rd_byte = rd_word[15:8];
                    timer_pkg::ACC_BOTH: rd_byte = read_hi_next[i] ? rd_word[15:8]
                        : rd_word[7:0];
                    default: rd_byte = rd_word[7:0];
                endcase
                if (status_latched[i])
                begin
                    rd_byte = status_val[i];
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            data_out <= 8'h00;
            data_oe <= 1'b0;
        end
        else
        begin
            data_out <= rd_byte;
            data_oe <= rd_act;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    for (g = 0; g < N; g++)
    begin : g_check
        a_status_copy_mode: assert property (@(posedge sys_clk) disable iff (!rst_n)
            mode_set[g] |=> status_mode[g] == $past(data_s2[5:0]) && null_count[g])
            else $error("mode write did not reach status copy");

        a_single_byte_fill: assert property (@(posedge sys_clk) disable iff (!rst_n)
            cnt_wr[g] && status_mode[g][5:4] == timer_pkg::ACC_LOW
            |=> count_reg[g][15:8] == 8'h00 && load_pending[g])
            else $error("single low byte write did not clear high byte");

        a_latch_holds_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
            count_latched[g] && !mode_set[g] && !rd_done[g] |=> $stable(latch_val[g]))
            else $error("held count changed before release");

        a_null_cleared_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
            transfer[g] && !cnt_wr[g] && !mode_set[g] |=> !null_count[g])
            else $error("null flag stayed set after transfer");

        a_status_read_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
            status_latched[g] && rd_act && port == 2'(g)
            |=> data_out == $past(status_val[g]) && data_oe)
            else $error("status byte not returned first");

        a_two_byte_pointer: assert property (@(posedge sys_clk) disable iff (!rst_n)
            rd_done[g] && !status_latched[g] && !mode_set[g]
            && status_mode[g][5:4] == timer_pkg::ACC_BOTH && !read_hi_next[g]
            |=> read_hi_next[g] && count_latched[g] == $past(count_latched[g]))
            else $error("low byte read did not advance pointer");
    end

    a_ctrl_read_silent: assert property (@(posedge sys_clk) disable iff (!rst_n)
        chip_sel && !bus_s2[timer_pkg::BUS_RD] && port == timer_pkg::PORT_CTRL |=> !data_oe)
        else $error("mode word port drove the data bus");

    a_no_select_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !chip_sel |=> !data_oe)
        else $error("bus driven without chip select");

endmodule

// File: verilog/timer_pkg.sv
// shared constants of the three-channel interval timer
package timer_pkg;

    // ****************************************
    // port decode
    // ****************************************
    localparam logic [1:0] PORT_CTR0 = 2'h0;
    localparam logic [1:0] PORT_CTR1 = 2'h1;
    localparam logic [1:0] PORT_CTR2 = 2'h2;
    localparam logic [1:0] PORT_CTRL = 2'h3;

    // ****************************************
    // mode word fields
    // ****************************************
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 6;
    localparam int ACC_MSB = 5;
    localparam int ACC_LSB = 4;
    localparam int MODE_MSB = 3;
    localparam int MODE_LSB = 1;
    localparam int BCD_BIT = 0;
    localparam int MULTI_NOCOUNT_BIT = 5;
    localparam int MULTI_NOSTATUS_BIT = 4;
    localparam int MULTI_SEL_LSB = 1;
    localparam logic [1:0] SEL_MULTI = 2'h3;

    // ****************************************
    // byte access codes
    // ****************************************
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LOW = 2'h1;
    localparam logic [1:0] ACC_HIGH = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;

    // ****************************************
    // count modes
    // ****************************************
    localparam logic [2:0] MODE_END_COUNT = 3'h0;
    localparam logic [2:0] MODE_ONE_SHOT = 3'h1;
    localparam logic [2:0] MODE_HW_STROBE = 3'h5;

    // ****************************************
    // counter layout and values
    // ****************************************
    localparam int NUM_COUNTERS = 3;
    localparam int COUNT_WIDTH = 16;
    localparam logic [7:0] FILL_BYTE = 8'h00;
    localparam logic [15:0] COUNT_ONE = 16'h0001;
    localparam logic [15:0] BIN_MAX = 16'hFFFF;
    localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;

    // ****************************************
    // synchronised bus bundle positions
    // ****************************************
    localparam int BUS_CS = 4;
    localparam int BUS_RD = 3;
    localparam int BUS_WR = 2;
    localparam int BUS_WIDTH = 5;

endpackage
